// ===== verilog/plc_pkg.sv
// Constants of the loopback control and status register
package plc_pkg;
  // ----------------------------------------------------------------
  // Register location and reset
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] LOOP_CTRL_ADDR = 5'h13;
  localparam logic [DATA_W-1:0] LOOP_CTRL_RESET = 16'h1041;
  // Bits 11 and 5:1 are read-only zero; 15:13 are writable spares
  localparam logic [DATA_W-1:0] LOOP_CTRL_WMASK = 16'hf7c1;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ALL_DIGITAL_SEL = 12;
  localparam int BIT_LINE_DRIVER_SEL = 10;
  localparam int BIT_REMOTE_EN = 9;
  localparam int BIT_RX_ISOLATE = 8;
  localparam int BIT_EXT_CABLE_EN = 7;
  localparam int BIT_TX_SUPPRESS = 6;
  localparam int BIT_LINK_GOOD_FORCE = 0;
endpackage : plc_pkg

// ===== verilog/plc_if.sv
// Carrier between the register and the loop mode decoder
`timescale 1ns/1ps
interface plc_if;
  logic all_digital_loop_select;
  logic line_driver_loop_select;
  logic remote_loop_enable;
  logic receive_isolate;
  logic external_cable_loop_enable;
  logic loop_transmit_suppress;
  logic loop_link_good_force;
  logic ieee_loopback;
  logic link_up;
  logic digital_loop_on;
  logic line_driver_loop_on;
  logic remote_loop_on;
  logic external_loop_on;
  logic rx_suppress_on;
  logic tx_suppress_on;
  logic link_force_on;
  modport regs (
    output all_digital_loop_select, line_driver_loop_select, remote_loop_enable,
    output receive_isolate, external_cable_loop_enable, loop_transmit_suppress,
    output loop_link_good_force, ieee_loopback, link_up,
    input digital_loop_on, line_driver_loop_on, remote_loop_on, external_loop_on,
    input rx_suppress_on, tx_suppress_on, link_force_on
  );
  modport decode (
    input all_digital_loop_select, line_driver_loop_select, remote_loop_enable,
    input receive_isolate, external_cable_loop_enable, loop_transmit_suppress,
    input loop_link_good_force, ieee_loopback, link_up,
    output digital_loop_on, line_driver_loop_on, remote_loop_on, external_loop_on,
    output rx_suppress_on, tx_suppress_on, link_force_on
  );
endinterface : plc_if

// ===== verilog/plc_loop_decode.sv
// Loop mode decoder from register fields and the standard loopback bit
`timescale 1ns/1ps
module plc_loop_decode (
  plc_if.decode bus
);
  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  // Line driver select takes the loopback bit over from all-digital
  wire ld_mode = bus.ieee_loopback & bus.line_driver_loop_select;
  wire dig_mode = bus.ieee_loopback & bus.all_digital_loop_select & ~ld_mode;
  wire rem_mode = bus.remote_loop_enable & bus.link_up;
  // Cable loop runs only with the standard loopback bit clear
  wire ext_mode = bus.external_cable_loop_enable & ~bus.ieee_loopback;
  wire any_loop = bus.ieee_loopback | rem_mode | ext_mode;

  assign bus.line_driver_loop_on = ld_mode;
  assign bus.digital_loop_on = dig_mode;
  assign bus.remote_loop_on = rem_mode;
  assign bus.external_loop_on = ext_mode;
  assign bus.rx_suppress_on = bus.receive_isolate & any_loop;
  assign bus.tx_suppress_on = bus.loop_transmit_suppress & dig_mode;
  assign bus.link_force_on = bus.loop_link_good_force & bus.ieee_loopback;
endmodule : plc_loop_decode

// ===== verilog/plc_loop_ctrl.sv
// Loopback control and status register with registered loop mode outputs
`timescale 1ns/1ps
module plc_loop_ctrl (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [plc_pkg::ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_wr_en,
  input wire logic [plc_pkg::DATA_W-1:0] mgmt_wr_data,
  input wire logic mgmt_rd_en,
  input wire logic ieee_loopback,
  input wire logic link_up,
  output logic [plc_pkg::DATA_W-1:0] mgmt_rd_data,
  output logic mgmt_rd_valid,
  output logic mgmt_rd_hit,
  output logic digital_loop_active,
  output logic line_driver_loop_active,
  output logic remote_loop_active,
  output logic external_loop_active,
  output logic mac_rx_suppress,
  output logic mdi_tx_suppress,
  output logic link_status_force_good
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_sync;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic [plc_pkg::DATA_W-1:0] ctrl_reg;
  wire addr_hit = (mgmt_addr == plc_pkg::LOOP_CTRL_ADDR);
  wire wr_hit = mgmt_wr_en & addr_hit;
  // Read-only bits are masked on write, so they can never read back set
  wire [plc_pkg::DATA_W-1:0] ctrl_next =
    wr_hit ? (mgmt_wr_data & plc_pkg::LOOP_CTRL_WMASK) : ctrl_reg;
  // A miss answers with zero and no hit, leaving the bus to other registers
  wire [plc_pkg::DATA_W-1:0] rd_data_next = addr_hit ? ctrl_reg : 16'h0000;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ctrl_reg <= plc_pkg::LOOP_CTRL_RESET;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      mgmt_rd_data <= 16'h0000;
      mgmt_rd_valid <= 1'b0;
      mgmt_rd_hit <= 1'b0;
    end else if (ce) begin
      mgmt_rd_data <= mgmt_rd_en ? rd_data_next : 16'h0000;
      mgmt_rd_valid <= mgmt_rd_en;
      mgmt_rd_hit <= mgmt_rd_en & addr_hit;
    end
  end

  // ----------------------------------------------------------------
  // Loop mode decode
  // ----------------------------------------------------------------
  plc_if lp ();

  assign lp.all_digital_loop_select = ctrl_reg[plc_pkg::BIT_ALL_DIGITAL_SEL];
  assign lp.line_driver_loop_select = ctrl_reg[plc_pkg::BIT_LINE_DRIVER_SEL];
  assign lp.remote_loop_enable = ctrl_reg[plc_pkg::BIT_REMOTE_EN];
  assign lp.receive_isolate = ctrl_reg[plc_pkg::BIT_RX_ISOLATE];
  assign lp.external_cable_loop_enable = ctrl_reg[plc_pkg::BIT_EXT_CABLE_EN];
  assign lp.loop_transmit_suppress = ctrl_reg[plc_pkg::BIT_TX_SUPPRESS];
  assign lp.loop_link_good_force = ctrl_reg[plc_pkg::BIT_LINK_GOOD_FORCE];
  assign lp.ieee_loopback = ieee_loopback;
  assign lp.link_up = link_up;

  plc_loop_decode u_decode (
    .bus(lp.decode)
  );

  // ----------------------------------------------------------------
  // Registered mode outputs
  // ----------------------------------------------------------------
  // One cycle of latency keeps every datapath control glitch free
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      digital_loop_active <= 1'b0;
      line_driver_loop_active <= 1'b0;
      remote_loop_active <= 1'b0;
      external_loop_active <= 1'b0;
      mac_rx_suppress <= 1'b0;
      mdi_tx_suppress <= 1'b0;
      link_status_force_good <= 1'b0;
    end else if (ce) begin
      digital_loop_active <= lp.digital_loop_on;
      line_driver_loop_active <= lp.line_driver_loop_on;
      remote_loop_active <= lp.remote_loop_on;
      external_loop_active <= lp.external_loop_on;
      mac_rx_suppress <= lp.rx_suppress_on;
      mdi_tx_suppress <= lp.tx_suppress_on;
      link_status_force_good <= lp.link_force_on;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_value;
    @(posedge clk_sys) $rose(rst_n_sync) |-> ctrl_reg == 16'h1041;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("Bad reset value");

  property p_write_mask;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && mgmt_wr_en && mgmt_addr == 5'h13 |=> ctrl_reg == ($past(mgmt_wr_data) & 16'hf7c1);
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("Write not stored");

  property p_read_back;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && mgmt_rd_en && mgmt_addr == 5'h13 && !mgmt_wr_en
      |=> mgmt_rd_valid && mgmt_rd_hit && mgmt_rd_data == $past(ctrl_reg);
  endproperty
  a_read_back: assert property (p_read_back) else $error("Read data wrong");

  // Sampled reset guard: the outputs still sit in reset at the release edge
  property p_digital;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      rst_n_sync && ce && ieee_loopback && ctrl_reg[12] && !ctrl_reg[10]
      |=> digital_loop_active && !line_driver_loop_active;
  endproperty
  a_digital: assert property (p_digital) else $error("Digital loop missing");

  property p_line_driver;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      rst_n_sync && ce && ieee_loopback && ctrl_reg[10]
      |=> line_driver_loop_active && !digital_loop_active;
  endproperty
  a_line_driver: assert property (p_line_driver) else $error("Line driver loop wrong");

  property p_remote;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync
      |=> remote_loop_active == ($past(ctrl_reg[9]) && $past(link_up));
  endproperty
  a_remote: assert property (p_remote) else $error("Remote loop wrong");

  property p_isolate;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ##1 (digital_loop_active || remote_loop_active || external_loop_active)
      && $past(ce) && $past(ctrl_reg[8]) |-> mac_rx_suppress;
  endproperty
  a_isolate: assert property (p_isolate) else $error("Receive not isolated");

  property p_external;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync
      |=> external_loop_active == ($past(ctrl_reg[7]) && !$past(ieee_loopback));
  endproperty
  a_external: assert property (p_external) else $error("External loop wrong");

  property p_tx_suppress;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce ##1 mdi_tx_suppress |-> digital_loop_active && $past(ctrl_reg[6]);
  endproperty
  a_tx_suppress: assert property (p_tx_suppress) else $error("Suppress outside loop");

  property p_link_force;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync
      |=> link_status_force_good == ($past(ctrl_reg[0]) && $past(ieee_loopback));
  endproperty
  a_link_force: assert property (p_link_force) else $error("Link force wrong");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ctrl_reg[11] == 1'b0 && ctrl_reg[5:1] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set");

  property p_digital_exact;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync |=> digital_loop_active ==
        ($past(ieee_loopback) && $past(ctrl_reg[12]) && !$past(ctrl_reg[10]));
  endproperty
  a_digital_exact: assert property (p_digital_exact) else $error("Digital loop stray");

  property p_rx_suppress_exact;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync |=> mac_rx_suppress == ($past(ctrl_reg[8]) && ($past(ieee_loopback)
        || ($past(ctrl_reg[9]) && $past(link_up)) || $past(ctrl_reg[7])));
  endproperty
  a_rx_suppress_exact: assert property (p_rx_suppress_exact) else $error("Isolate wrong");

  property p_tx_suppress_exact;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync |=> mdi_tx_suppress == ($past(ctrl_reg[6]) && $past(ieee_loopback)
        && $past(ctrl_reg[12]) && !$past(ctrl_reg[10]));
  endproperty
  a_tx_suppress_exact: assert property (p_tx_suppress_exact) else $error("Suppress wrong");

  property p_read_miss;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync && mgmt_rd_en && mgmt_addr != plc_pkg::LOOP_CTRL_ADDR
      |=> mgmt_rd_valid && !mgmt_rd_hit && mgmt_rd_data == 16'h0000;
  endproperty
  a_read_miss: assert property (p_read_miss) else $error("Miss read wrong");

  property p_read_idle;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync && !mgmt_rd_en
      |=> !mgmt_rd_valid && !mgmt_rd_hit && mgmt_rd_data == 16'h0000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("Read answer without request");

  property p_write_miss;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      ce && rst_n_sync && !(mgmt_wr_en && mgmt_addr == plc_pkg::LOOP_CTRL_ADDR)
      |=> $stable(ctrl_reg);
  endproperty
  a_write_miss: assert property (p_write_miss) else $error("Register moved without write");

  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      !ce |=> $stable(ctrl_reg) && $stable(mgmt_rd_valid);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved without enable");

  property p_freeze_modes;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      !ce |=> $stable(digital_loop_active) && $stable(line_driver_loop_active)
        && $stable(remote_loop_active) && $stable(external_loop_active)
        && $stable(mac_rx_suppress) && $stable(mdi_tx_suppress)
        && $stable(link_status_force_good);
  endproperty
  a_freeze_modes: assert property (p_freeze_modes) else $error("Mode moved without enable");
endmodule : plc_loop_ctrl

// ===== tb/plc_host_model.sv
// Station management host model driving the register port
`timescale 1ns/1ps
module plc_host_model (
  input wire logic clk_sys,
  input wire logic [plc_pkg::DATA_W-1:0] mgmt_rd_data,
  input wire logic mgmt_rd_valid,
  input wire logic mgmt_rd_hit,
  output logic [plc_pkg::ADDR_W-1:0] mgmt_addr,
  output logic mgmt_wr_en,
  output logic [plc_pkg::DATA_W-1:0] mgmt_wr_data,
  output logic mgmt_rd_en
);
  initial begin
    mgmt_addr = 5'h00;
    mgmt_wr_en = 1'b0;
    mgmt_wr_data = 16'h0000;
    mgmt_rd_en = 1'b0;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    mgmt_addr <= a;
    mgmt_wr_data <= d;
    mgmt_wr_en <= 1'b1;
    @(posedge clk_sys);
    mgmt_wr_en <= 1'b0;
    mgmt_addr <= ~a;
    mgmt_wr_data <= ~d;
  endtask : write
  task automatic read(input logic [4:0] a, output logic [15:0] d, output logic v, h);
    @(posedge clk_sys);
    mgmt_addr <= a;
    mgmt_rd_en <= 1'b1;
    @(posedge clk_sys);
    mgmt_rd_en <= 1'b0;
    mgmt_addr <= ~a;
    #1;
    d = mgmt_rd_data;
    v = mgmt_rd_valid;
    h = mgmt_rd_hit;
  endtask : read
endmodule : plc_host_model

// ===== tb/phy_loopback_control_tb_top.sv
// Self-checking testbench of the loopback control register
`timescale 1ns/1ps
module phy_loopback_control_tb_top;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic ieee_loopback = 1'b0;
  logic link_up = 1'b0;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr_en, rd_en, rvalid, rhit;
  logic dig, ld, rem, ext, rxs, txs, lfg;
  int miscompares = 0;
  int comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  plc_host_model plc_host_model_i (.clk_sys(clk_sys), .mgmt_rd_data(rdata),
    .mgmt_rd_valid(rvalid), .mgmt_rd_hit(rhit), .mgmt_addr(addr), .mgmt_wr_en(wr_en),
    .mgmt_wr_data(wdata), .mgmt_rd_en(rd_en));
  plc_loop_ctrl plc_loop_ctrl_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .mgmt_addr(addr), .mgmt_wr_en(wr_en), .mgmt_wr_data(wdata), .mgmt_rd_en(rd_en),
    .ieee_loopback(ieee_loopback), .link_up(link_up), .mgmt_rd_data(rdata),
    .mgmt_rd_valid(rvalid), .mgmt_rd_hit(rhit), .digital_loop_active(dig),
    .line_driver_loop_active(ld), .remote_loop_active(rem), .external_loop_active(ext),
    .mac_rx_suppress(rxs), .mdi_tx_suppress(txs), .link_status_force_good(lfg));
  task conclude;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  task chk16(input string n, input logic [15:0] e, s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk16
  // Mode vector order: digital, line driver, remote, external, rx, tx, link
  task chk7(input logic [6:0] e);
    comparisons++;
    if ({dig, ld, rem, ext, rxs, txs, lfg} !== e) begin
      miscompares++;
      $display("wrong value modes expected %b seen %b", e, {dig, ld, rem, ext, rxs, txs, lfg});
    end
  endtask : chk7
  task rd(input logic [4:0] a, input logic [15:0] e, input logic eh);
    logic [15:0] d;
    logic v, h;
    plc_host_model_i.read(a, d, v, h);
    chk16("read data", e, d);
    chk16("read valid hit", {14'h0000, 1'b1, eh}, {14'h0000, v, h});
  endtask : rd
  task setin(input logic i, l);
    @(posedge clk_sys);
    ieee_loopback <= i;
    link_up <= l;
  endtask : setin
  // Mode outputs lag their causes by one cycle
  task settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  task t_reset;
    setin(1'b1, 1'b0);
    settle;
    rd(5'h13, 16'h1041, 1'b1);
    chk7(7'b1000011);
  endtask : t_reset
  task t_fields;
    plc_host_model_i.write(5'h13, 16'hffff);
    rd(5'h13, 16'hf7c1, 1'b1);
    settle;
    chk7(7'b0100101);
    plc_host_model_i.write(5'h12, 16'h0000);
    rd(5'h12, 16'h0000, 1'b0);
    rd(5'h13, 16'hf7c1, 1'b1);
  endtask : t_fields
  task t_remote;
    setin(1'b0, 1'b1);
    plc_host_model_i.write(5'h13, 16'h0280);
    settle;
    chk7(7'b0011000);
    plc_host_model_i.write(5'h13, 16'h0380);
    settle;
    chk7(7'b0011100);
    setin(1'b0, 1'b0);
    settle;
    chk7(7'b0001100);
    plc_host_model_i.write(5'h13, 16'h0100);
    settle;
    chk7(7'b0000000);
  endtask : t_remote
  task t_suppress;
    setin(1'b1, 1'b0);
    plc_host_model_i.write(5'h13, 16'h1000);
    settle;
    chk7(7'b1000000);
    plc_host_model_i.write(5'h13, 16'h1440);
    settle;
    chk7(7'b0100000);
  endtask : t_suppress
  // Enable low must drop requests and hold the modes though inputs move
  task t_freeze;
    logic [15:0] d;
    logic v, h;
    @(posedge clk_sys);
    ce <= 1'b0;
    plc_host_model_i.write(5'h13, 16'h1000);
    plc_host_model_i.read(5'h13, d, v, h);
    chk16("frozen read data", 16'h0000, d);
    chk16("frozen read valid hit", 16'h0000, {14'h0000, v, h});
    setin(1'b0, 1'b1);
    settle;
    chk7(7'b0100000);
    @(posedge clk_sys);
    ce <= 1'b1;
    settle;
    chk7(7'b0000000);
    rd(5'h13, 16'h1440, 1'b1);
  endtask : t_freeze
  // Second reset in mid-run with the standard loopback bit held set
  task t_reset_again;
    @(posedge clk_sys);
    resetn <= 1'b0;
    ieee_loopback <= 1'b1;
    link_up <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk7(7'b0000000);
    @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(5'h13, 16'h1041, 1'b1);
    chk7(7'b1000011);
  endtask : t_reset_again
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset;
    t_fields;
    t_remote;
    t_suppress;
    t_freeze;
    t_reset_again;
    conclude;
  end
  // Tests need under a hundred cycles; this span leaves ample margin
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    conclude;
  end
endmodule : phy_loopback_control_tb_top
